// File: inc/mxt_pkg.sv
// macro instruction transform: shared constants and types
// assumes the host cpu timing pulses are far slower than MCLK
package mxt_pkg;

  // ---------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------
  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_XFORM = 1'b1
  } mxt_state_t;

  // ---------------------------------------------------------
  // macro instruction fields (bit 15 is the msb, I00)
  // ---------------------------------------------------------
  localparam int F_LSB = 12;
  localparam int F1_LSB = 8;
  localparam logic [3:0] F_REGREF = 4'h0;
  localparam logic [3:0] F1_ENH_A = 4'h4;
  localparam logic [3:0] F1_ENH_B = 4'h5;
  localparam logic [3:0] F1_SKIP_A = 4'h0;
  localparam logic [3:0] F1_SKIP_B = 4'h1;
  localparam logic [3:0] F1_SKIP_C = 4'h6;
  localparam logic [3:0] F1_SEXT_A = 4'h2;
  localparam logic [3:0] F1_SEXT_B = 4'h3;
  localparam logic [3:0] F1_ALLONE = 4'h8;
  localparam logic [3:0] F1_INTR = 4'hE;

  // ---------------------------------------------------------
  // micro address transform
  // ---------------------------------------------------------
  localparam logic [3:0] J_STORAGE_REF = 4'hB;
  localparam logic [7:0] MA_SREF_BASE = 8'h38;
  localparam logic [7:0] MA_REG_BASE = 8'h10;

  // ---------------------------------------------------------
  // k transform and encoded upper micro word fields
  // ---------------------------------------------------------
  localparam logic [2:0] K_FIELD_LS = 3'h7;
  localparam logic [7:0] K_FIELD_LS_VAL = 8'h0C;
  localparam logic [4:0] ALU_ADD = 5'h18;
  localparam logic [2:0] A_FILE1 = 3'h6;
  localparam logic [2:0] B_QREG = 3'h4;
  localparam logic [2:0] D_X_AND_AB = 3'h6;
  localparam logic [3:0] DEC_CORR = 4'h6;
  localparam logic [15:0] TOP_LOC = 16'h00FF;

  // ---------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------
  localparam logic [7:0] MA_N_RST = 8'hFF;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // idle pin levels in sync order: data, bad digits, gates/levels, pulses
  localparam logic [81:0] PIN_IDLE = {64'h0, 4'hF, 7'h62, 7'h36};
  localparam logic [6:0] LVL_IDLE = 7'h36;

endpackage : mxt_pkg

// File: logic/mxt_offset_xlat.sv
// offset (delta) and decimal-correction translator, combinational
// assumes instruction and prime byte are already registered
`timescale 1ns/1ps
module mxt_offset_xlat
(
  input wire logic [15:0] instr,
  input wire logic [7:0] low,
  input wire logic [3:0] bad_n,
  output logic [15:0] result
);

  // ---------------------------------------------------------
  // translation select
  // ---------------------------------------------------------
  logic [3:0] f;
  logic [3:0] f1;
  logic [15:0] corr;

  assign f = instr[15:12];
  assign f1 = instr[11:8];

  // one correction nibble per flagged digit
  always_comb
  begin
    corr = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      if (!bad_n[i])
        corr[i*4 +: 4] = mxt_pkg::DEC_CORR;
    end
  end

  // bad digit flags take the output over from the offset path
  always_comb
  begin
    if (bad_n != 4'hF)
      result = corr;
    else if (f != mxt_pkg::F_REGREF)
      result = {8'h00, low};
    else if (f1 == mxt_pkg::F1_SKIP_A || f1 == mxt_pkg::F1_SKIP_B ||
             f1 == mxt_pkg::F1_SKIP_C)
      result = {12'h000, low[3:0]};
    else if (f1 == mxt_pkg::F1_SEXT_A || f1 == mxt_pkg::F1_SEXT_B)
      result = {{8{low[7]}}, low};
    else if (f1 == mxt_pkg::F1_ALLONE)
      result = 16'hFFFF;
    else if (f1 == mxt_pkg::F1_INTR)
      result = {8'h01, low};
    else
      result = {8'h00, low};
  end

endmodule : mxt_offset_xlat

// File: logic/mxt_core.sv
// macro instruction transform: holding registers, micro address,
// offset operand, encoded upper micro word, k load and status pins
// assumes every host pin is asynchronous to MCLK and held for
// several MCLK periods; events are taken from pin edges
`timescale 1ns/1ps
module mxt_core
#(
  parameter int MA_W = 8
)
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic XFORM_NEXT_CMD,
  input wire logic FIFTH_TIME_PULSE,
  input wire logic INSTR_REG_LOAD_N,
  input wire logic FETCH_AND_XFORM_N,
  input wire logic MICRO_WORD_LOAD_N,
  input wire logic MICRO_WORD_CLEAR,
  input wire logic MEM_ADDR_REG_CLOCK_N,
  input wire logic STORE_STATUS,
  input wire logic LATE_MASTER_CLEAR_N,
  input wire logic PC_INCREMENT,
  input wire logic DELTA_PATH_SELECT_BIT,
  input wire logic [3:0] BAD_DIGIT_SEL_N,
  input wire logic PROTECT_BIT,
  input wire logic LOWER_WORD_BUS_GATE_N,
  input wire logic UPPER_WORD_BUS_GATE_N,
  input wire logic [15:0] MEM_DATA,
  input wire logic [15:0] MACRO_ADDR_REG,
  input wire logic [15:0] MICRO_WORD_LOWER,
  input wire logic [15:0] MICRO_WORD_ROM,
  output logic [MA_W-1:0] MICRO_ADDR_N,
  output logic NEXT_ADDR_LOAD,
  output logic [15:0] OFFSET_XLAT_OUT,
  output logic ALU_A_FROM_OFFSET,
  output logic [15:0] MICRO_WORD_UPPER,
  output logic UPPER_ROM_DISABLE,
  output logic [7:0] MICRO_INSTR_REG,
  output logic [2:0] K_XFORM_SEL,
  output logic [7:0] K_REG_VALUE,
  output logic K_REG_LOAD,
  output logic HALT_INTR_BLOCK_N,
  output logic UPPER_LOWER_SELECT_N,
  output logic INDEX_AT_TOP_LOCATION,
  output logic PROTECT_STATE_N,
  output logic [15:0] BUS_OUT,
  output logic BUS_OE_N
);

  // ---------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------
  // 256 micro words per page need exactly eight address lines
  if (MA_W != 8)
  begin : g_bad_ma_w
    $error("mxt_core: MA_W must be 8");
  end

  // ---------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------
  logic rst_q1;
  logic rst_n;
  logic [81:0] pin_raw;
  logic [81:0] s1;
  logic [81:0] s2;
  logic [6:0] s3;

  // async assert, release through two flops
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // slash pins kept low-active through the sync
  assign pin_raw = {MEM_DATA, MACRO_ADDR_REG, MICRO_WORD_LOWER,
                    MICRO_WORD_ROM, BAD_DIGIT_SEL_N,
                    UPPER_WORD_BUS_GATE_N, LOWER_WORD_BUS_GATE_N,
                    PROTECT_BIT, DELTA_PATH_SELECT_BIT, STORE_STATUS,
                    LATE_MASTER_CLEAR_N, MICRO_WORD_CLEAR,
                    PC_INCREMENT, MEM_ADDR_REG_CLOCK_N,
                    MICRO_WORD_LOAD_N, FIFTH_TIME_PULSE,
                    FETCH_AND_XFORM_N, INSTR_REG_LOAD_N,
                    XFORM_NEXT_CMD};

  // s1 feeds s2 only; s3 is the edge history of the pulse group
  // reset to idle pin levels so release shows no false edge or gate
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= mxt_pkg::PIN_IDLE;
      s2 <= mxt_pkg::PIN_IDLE;
      s3 <= mxt_pkg::LVL_IDLE;
    end
    else
    begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2[6:0];
    end
  end

  // ---------------------------------------------------------
  // synchronised pins and edge events
  // ---------------------------------------------------------
  logic [15:0] mem_data;
  logic [15:0] addr;
  logic [15:0] mm_low;
  logic [15:0] mm_rom;
  logic [3:0] bad_n;
  logic ug_n;
  logic lg_n;
  logic prot_bit;
  logic delta_path_select_bit;
  logic store;
  logic mc_n;
  logic clr;
  logic [6:0] lvl;
  logic [6:0] rise;
  logic [6:0] fall;
  logic ev_xf;
  logic ev_irl;
  logic ev_fetch;
  logic ev_t5;
  logic ev_mwl;
  logic ev_ab;
  logic ev_pc;

  assign {mem_data, addr, mm_low, mm_rom, bad_n, ug_n, lg_n, prot_bit,
          delta_path_select_bit, store, mc_n, clr, lvl} = s2;
  assign rise = lvl & ~s3;
  assign fall = ~lvl & s3;
  assign ev_xf = rise[0];
  // holding register load gate acts on its rising edge
  assign ev_irl = rise[1];
  assign ev_fetch = fall[2];
  assign ev_t5 = rise[3];
  assign ev_mwl = fall[4];
  assign ev_pc = rise[6];
  assign ev_ab = fall[5];

  // ---------------------------------------------------------
  // decode of the held instruction
  // ---------------------------------------------------------
  logic [15:0] ihold;
  logic [7:0] ilow;
  logic [3:0] f;
  logic [3:0] f1;
  logic sref;
  logic enh;
  logic [15:0] enc;
  logic [7:0] ma;
  logic [15:0] xlat;

  assign f = ihold[mxt_pkg::F_LSB +: 4];
  assign f1 = ihold[mxt_pkg::F1_LSB +: 4];
  assign sref = (f != mxt_pkg::F_REGREF);
  assign enh = !sref && (f1 == mxt_pkg::F1_ENH_A ||
                         f1 == mxt_pkg::F1_ENH_B);

  // storage reference takes the j = B transform, others F1
  always_comb
  begin
    if (sref)
      ma = mxt_pkg::MA_SREF_BASE + {1'b0, f, 3'b000};
    else
      ma = mxt_pkg::MA_REG_BASE + {2'b00, f1, 2'b00};
  end

  // encoder runs beside the address and offset paths
  // storage reference forms the add word for the address
  assign enc = sref ? {mxt_pkg::ALU_ADD, mxt_pkg::A_FILE1,
                       mxt_pkg::B_QREG, mxt_pkg::D_X_AND_AB, 2'b00}
                    : mxt_pkg::WORD_RST;

  // holding and prime registers feed the translator
  // bad digit flags steer the correction outputs
  mxt_offset_xlat u_xlat
  (
    .instr(ihold),
    .low(ilow),
    .bad_n(bad_n),
    .result(xlat)
  );

  // ---------------------------------------------------------
  // transform sequencer and output registers
  // ---------------------------------------------------------
  mxt_pkg::mxt_state_t state;
  mxt_pkg::mxt_state_t next_state;
  logic [15:0] next_ihold;
  logic [7:0] next_ilow;
  logic [7:0] next_ma_n;
  logic next_naload;
  logic [15:0] next_off;
  logic next_alu_a;
  logic [15:0] next_upper;
  logic next_rom_dis;
  logic [7:0] next_mir;
  logic [2:0] next_ksel;
  logic [7:0] next_kval;
  logic next_kload;
  logic next_hblk_n;
  logic next_idx;
  logic next_prot_n;
  logic [15:0] next_bus;
  logic next_oe_n;

  // register loads are edge events and hold between them; alu A select, rom disable and bus follow pin levels every cycle
  always_comb
  begin
    next_state = state;
    next_ihold = ihold;
    next_ilow = ilow;
    next_ma_n = MICRO_ADDR_N;
    next_naload = 1'b0;
    next_off = OFFSET_XLAT_OUT;
    next_upper = MICRO_WORD_UPPER;
    next_mir = MICRO_INSTR_REG;
    next_ksel = K_XFORM_SEL;
    next_kval = K_REG_VALUE;
    next_kload = 1'b0;
    next_hblk_n = HALT_INTR_BLOCK_N;
    next_idx = INDEX_AT_TOP_LOCATION;
    next_prot_n = PROTECT_STATE_N;
    // clear delta path bit hands A input to the offset
    next_alu_a = !delta_path_select_bit;
    // upper roms off for the whole transform command
    next_rom_dis = lvl[0] || !lvl[2];
    // transform command fills holding and prime registers
    // fetch command fills them and runs both transforms
    if (ev_xf || ev_fetch)
    begin
      next_ihold = mem_data;
      next_ilow = mem_data[7:0];
      next_state = mxt_pkg::ST_XFORM;
      // protect bit of the taken word sets protect state
      if (prot_bit)
        next_prot_n = 1'b0;
    end
    else if (ev_irl)
    begin
      next_ihold = mem_data;
    end
    case (state)
      mxt_pkg::ST_IDLE:
      begin
        next_state = next_state;
      end
      mxt_pkg::ST_XFORM:
      begin
        next_ma_n = ~ma;
        next_naload = 1'b1;
        // translator result onto the sixteen offset lines
        next_off = xlat;
        // field load/store k transform on every command
        next_ksel = mxt_pkg::K_FIELD_LS;
        next_kval = mxt_pkg::K_FIELD_LS_VAL;
        next_kload = 1'b1;
        next_state = mxt_pkg::ST_IDLE;
      end
      default:
      begin
        next_state = mxt_pkg::ST_IDLE;
      end
    endcase
    // upper word only moves on the fifth timing pulse
    if (ev_t5)
      next_upper = UPPER_ROM_DISABLE ? enc : mm_rom;
    // clear outranks a load strobe in the same cycle
    // load strobe takes bits 24-31 of the lower word
    if (clr)
      next_mir = mxt_pkg::BYTE_RST;
    else if (ev_mwl)
      next_mir = mm_low[7:0];
    // top location test latched only under store status
    if (ev_ab && store)
      next_idx = (addr == mxt_pkg::TOP_LOC);
    // block on memory ref or enhanced, set beats release
    // block held until increment so no halt branch
    // master clear releases block and protect
    if (!mc_n)
    begin
      next_hblk_n = 1'b1;
      next_prot_n = 1'b1;
    end
    else if (state == mxt_pkg::ST_XFORM && (sref || enh))
      next_hblk_n = 1'b0;
    else if (ev_pc)
      next_hblk_n = 1'b1;
    // lower gate wins if both gates are low at once
    next_oe_n = 1'b0;
    if (!lg_n)
      next_bus = mm_low;
    else if (!ug_n)
      next_bus = MICRO_WORD_UPPER;
    else
    begin
      next_bus = mxt_pkg::WORD_RST;
      next_oe_n = 1'b1;
    end
  end

  // registers only; every output leaves from here
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= mxt_pkg::ST_IDLE;
      ihold <= mxt_pkg::WORD_RST;
      ilow <= mxt_pkg::BYTE_RST;
      MICRO_ADDR_N <= mxt_pkg::MA_N_RST;
      NEXT_ADDR_LOAD <= 1'b0;
      OFFSET_XLAT_OUT <= mxt_pkg::WORD_RST;
      ALU_A_FROM_OFFSET <= 1'b0;
      MICRO_WORD_UPPER <= mxt_pkg::WORD_RST;
      UPPER_ROM_DISABLE <= 1'b0;
      MICRO_INSTR_REG <= mxt_pkg::BYTE_RST;
      K_XFORM_SEL <= 3'h0;
      K_REG_VALUE <= mxt_pkg::BYTE_RST;
      K_REG_LOAD <= 1'b0;
      HALT_INTR_BLOCK_N <= 1'b1;
      INDEX_AT_TOP_LOCATION <= 1'b0;
      UPPER_LOWER_SELECT_N <= 1'b1;
      PROTECT_STATE_N <= 1'b1;
      BUS_OUT <= mxt_pkg::WORD_RST;
      BUS_OE_N <= 1'b1;
    end
    else
    begin
      state <= next_state;
      ihold <= next_ihold;
      ilow <= next_ilow;
      MICRO_ADDR_N <= next_ma_n;
      NEXT_ADDR_LOAD <= next_naload;
      OFFSET_XLAT_OUT <= next_off;
      ALU_A_FROM_OFFSET <= next_alu_a;
      MICRO_WORD_UPPER <= next_upper;
      UPPER_ROM_DISABLE <= next_rom_dis;
      MICRO_INSTR_REG <= next_mir;
      K_XFORM_SEL <= next_ksel;
      K_REG_VALUE <= next_kval;
      K_REG_LOAD <= next_kload;
      HALT_INTR_BLOCK_N <= next_hblk_n;
      INDEX_AT_TOP_LOCATION <= next_idx;
      // upper half selected while index sits at the top
      UPPER_LOWER_SELECT_N <= !next_idx;
      PROTECT_STATE_N <= next_prot_n;
      BUS_OUT <= next_bus;
      BUS_OE_N <= next_oe_n;
    end
  end

  // ---------------------------------------------------------
  // assertions
  // ---------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_take;
    (ev_xf || ev_fetch) ##1 (state == mxt_pkg::ST_XFORM);
  endsequence

  a_take_both_regs: assert property ((ev_xf || ev_fetch) |=>
    ihold == $past(mem_data) && ilow == $past(mem_data[7:0]))
    else $error("holding registers missed the memory word");

  a_new_ma_out: assert property (s_take |=>
    MICRO_ADDR_N == ~$past(ma) && NEXT_ADDR_LOAD)
    else $error("micro address not driven after transform");

  a_offset_out: assert property (s_take |=>
    OFFSET_XLAT_OUT == $past(xlat))
    else $error("offset lines do not show translator result");

  a_k_load_once: assert property (s_take |=>
    K_REG_LOAD && K_REG_VALUE == 8'h0C && K_XFORM_SEL == 3'h7
    ##1 !K_REG_LOAD)
    else $error("k transform 7 not loaded exactly once");

  a_enc_at_t5: assert property ((ev_t5 && UPPER_ROM_DISABLE && sref)
    |=> MICRO_WORD_UPPER == 16'hC698)
    else $error("encoded add word not loaded at fifth pulse");

  a_alu_a_path: assert property ($past(rst_n) |->
    ALU_A_FROM_OFFSET == !$past(delta_path_select_bit))
    else $error("alu A source does not follow delta path bit");

  a_irl_load: assert property ((ev_irl && !ev_xf && !ev_fetch) |=>
    ihold == $past(mem_data) && ilow == $past(ilow))
    else $error("holding register missed its load gate");

  a_mir_clear: assert property (clr |=>
    MICRO_INSTR_REG == 8'h00)
    else $error("micro register not cleared");

  a_halt_block: assert property ((state == mxt_pkg::ST_XFORM && sref
    && mc_n) |=> !HALT_INTR_BLOCK_N)
    else $error("halt block not asserted on memory reference");

  a_master_clr: assert property (!mc_n |=>
    HALT_INTR_BLOCK_N && PROTECT_STATE_N)
    else $error("master clear left block or protect active");

  a_bus_lower: assert property (!lg_n |=>
    BUS_OUT == $past(mm_low) && !BUS_OE_N)
    else $error("lower word not placed on bus");

  a_top_index: assert property ((ev_ab && store) |=>
    INDEX_AT_TOP_LOCATION == ($past(addr) == 16'h00FF)
    && UPPER_LOWER_SELECT_N == !INDEX_AT_TOP_LOCATION)
    else $error("top location indication wrong");

endmodule : mxt_core

// File: tb/mxt_host_model.sv
// host cpu side: upper micro rom, lower micro word and bus level
// assumes micro address pins are active low and settle well before use
`timescale 1ns/1ps
module mxt_host_model
(
  input wire logic MCLK,
  input wire logic [7:0] MICRO_ADDR_N,
  input wire logic UPPER_ROM_DISABLE,
  input wire logic [15:0] BUS_OUT,
  input wire logic BUS_OE_N,
  output logic [15:0] MICRO_WORD_ROM,
  output logic [15:0] MICRO_WORD_LOWER,
  output logic [15:0] BUS_LEVEL
);
  logic [7:0] addr;
  logic [15:0] last_rom = 16'h0000;
  logic [15:0] last_bus = 16'h0000;

  // ---------------------------------------------------------
  // micro memory contents
  // ---------------------------------------------------------
  assign addr = ~MICRO_ADDR_N;
  assign MICRO_WORD_LOWER = {~addr, addr};
  // rom released
  // a disabled rom no longer holds its word: show the inverse instead
  assign MICRO_WORD_ROM = UPPER_ROM_DISABLE ? ~last_rom :
    {8'hA5 ^ addr, addr};
  // bus resolution
  // undriven bus has no pull, so it flips away from the last value
  assign BUS_LEVEL = !BUS_OE_N ? BUS_OUT : ~last_bus;

  // remember what was last driven on each shared line
  always_ff @(posedge MCLK)
  begin
    if (!UPPER_ROM_DISABLE)
      last_rom <= MICRO_WORD_ROM;
    if (!BUS_OE_N)
      last_bus <= BUS_OUT;
  end
endmodule : mxt_host_model

// File: tb/mxt_core_tb.sv
// self-checking bench for the macro instruction transform core
// assumes pins change at the falling edge and are held many cycles
`timescale 1ns/1ps
module mxt_core_tb;
  logic MCLK = 1'b0, RST_B = 1'b0, XFORM_NEXT_CMD = 1'b0;
  logic FIFTH_TIME_PULSE = 1'b0, INSTR_REG_LOAD_N = 1'b1;
  logic FETCH_AND_XFORM_N = 1'b1, MICRO_WORD_LOAD_N = 1'b1;
  logic MICRO_WORD_CLEAR = 1'b0, MEM_ADDR_REG_CLOCK_N = 1'b1;
  logic STORE_STATUS = 1'b0, LATE_MASTER_CLEAR_N = 1'b1;
  logic PC_INCREMENT = 1'b0, DELTA_PATH_SELECT_BIT = 1'b0;
  logic [3:0] BAD_DIGIT_SEL_N = 4'hF;
  logic PROTECT_BIT = 1'b1, LOWER_WORD_BUS_GATE_N = 1'b1;
  logic UPPER_WORD_BUS_GATE_N = 1'b1;
  logic [15:0] MEM_DATA = 16'h0000, MACRO_ADDR_REG = 16'h0000;
  logic [15:0] MICRO_WORD_LOWER, MICRO_WORD_ROM, BUS_LEVEL;
  logic [7:0] MICRO_ADDR_N, MICRO_INSTR_REG, K_REG_VALUE;
  logic [15:0] OFFSET_XLAT_OUT, MICRO_WORD_UPPER, BUS_OUT;
  logic [2:0] K_XFORM_SEL;
  logic NEXT_ADDR_LOAD, ALU_A_FROM_OFFSET, UPPER_ROM_DISABLE, K_REG_LOAD;
  logic HALT_INTR_BLOCK_N, UPPER_LOWER_SELECT_N, INDEX_AT_TOP_LOCATION;
  logic PROTECT_STATE_N, BUS_OE_N;
  int fail_count = 0;
  int n_tests = 0;
  int na_cnt = 0;
  int kl_cnt = 0;

  mxt_core uut (.MCLK(MCLK), .RST_B(RST_B),
    .XFORM_NEXT_CMD(XFORM_NEXT_CMD), .FIFTH_TIME_PULSE(FIFTH_TIME_PULSE),
    .INSTR_REG_LOAD_N(INSTR_REG_LOAD_N),
    .FETCH_AND_XFORM_N(FETCH_AND_XFORM_N),
    .MICRO_WORD_LOAD_N(MICRO_WORD_LOAD_N),
    .MICRO_WORD_CLEAR(MICRO_WORD_CLEAR),
    .MEM_ADDR_REG_CLOCK_N(MEM_ADDR_REG_CLOCK_N),
    .STORE_STATUS(STORE_STATUS), .LATE_MASTER_CLEAR_N(LATE_MASTER_CLEAR_N),
    .PC_INCREMENT(PC_INCREMENT),
    .DELTA_PATH_SELECT_BIT(DELTA_PATH_SELECT_BIT),
    .BAD_DIGIT_SEL_N(BAD_DIGIT_SEL_N), .PROTECT_BIT(PROTECT_BIT),
    .LOWER_WORD_BUS_GATE_N(LOWER_WORD_BUS_GATE_N),
    .UPPER_WORD_BUS_GATE_N(UPPER_WORD_BUS_GATE_N), .MEM_DATA(MEM_DATA),
    .MACRO_ADDR_REG(MACRO_ADDR_REG), .MICRO_WORD_LOWER(MICRO_WORD_LOWER),
    .MICRO_WORD_ROM(MICRO_WORD_ROM), .MICRO_ADDR_N(MICRO_ADDR_N),
    .NEXT_ADDR_LOAD(NEXT_ADDR_LOAD), .OFFSET_XLAT_OUT(OFFSET_XLAT_OUT),
    .ALU_A_FROM_OFFSET(ALU_A_FROM_OFFSET),
    .MICRO_WORD_UPPER(MICRO_WORD_UPPER),
    .UPPER_ROM_DISABLE(UPPER_ROM_DISABLE),
    .MICRO_INSTR_REG(MICRO_INSTR_REG), .K_XFORM_SEL(K_XFORM_SEL),
    .K_REG_VALUE(K_REG_VALUE), .K_REG_LOAD(K_REG_LOAD),
    .HALT_INTR_BLOCK_N(HALT_INTR_BLOCK_N),
    .UPPER_LOWER_SELECT_N(UPPER_LOWER_SELECT_N),
    .INDEX_AT_TOP_LOCATION(INDEX_AT_TOP_LOCATION),
    .PROTECT_STATE_N(PROTECT_STATE_N), .BUS_OUT(BUS_OUT),
    .BUS_OE_N(BUS_OE_N));

  mxt_host_model host (.MCLK(MCLK), .MICRO_ADDR_N(MICRO_ADDR_N),
    .UPPER_ROM_DISABLE(UPPER_ROM_DISABLE), .BUS_OUT(BUS_OUT),
    .BUS_OE_N(BUS_OE_N), .MICRO_WORD_ROM(MICRO_WORD_ROM),
    .MICRO_WORD_LOWER(MICRO_WORD_LOWER), .BUS_LEVEL(BUS_LEVEL));

  // ---------------------------------------------------------
  // clock, pulse counters and helpers
  // ---------------------------------------------------------
  initial
  begin
    forever #5 MCLK = ~MCLK;
  end

  // pulses stand one cycle, so they are counted rather than sampled
  always @(posedge MCLK)
  begin
    if (NEXT_ADDR_LOAD === 1'b1)
      na_cnt++;
    if (K_REG_LOAD === 1'b1)
      kl_cnt++;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge MCLK);
  endtask : idle

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  // one whole transform: release the halt block, issue, check, fifth pulse
  task automatic xform(input logic [15:0] d, input logic [3:0] bad,
    input logic [7:0] ma_n, input logic [15:0] off, input logic blk,
    input logic [15:0] enc, input bit fetch);
    int na0;
    int kl0;
    PC_INCREMENT = 1'b1;
    idle(4);
    PC_INCREMENT = 1'b0;
    idle(5);
    chk({15'h0, HALT_INTR_BLOCK_N}, 16'h0001);
    MEM_DATA = d;
    BAD_DIGIT_SEL_N = bad;
    idle(4);
    na0 = na_cnt;
    kl0 = kl_cnt;
    if (fetch)
      FETCH_AND_XFORM_N = 1'b0;
    else
      XFORM_NEXT_CMD = 1'b1;
    idle(8);
    chk({8'h00, MICRO_ADDR_N}, {8'h00, ma_n});
    chk(OFFSET_XLAT_OUT, off);
    chk(16'(na_cnt - na0), 16'h0001);
    chk(16'(kl_cnt - kl0), 16'h0001);
    chk({13'h0, K_XFORM_SEL}, 16'h0007);
    chk({8'h00, K_REG_VALUE}, 16'h000C);
    chk({15'h0, HALT_INTR_BLOCK_N}, {15'h0, blk});
    chk({15'h0, UPPER_ROM_DISABLE}, 16'h0001);
    FIFTH_TIME_PULSE = 1'b1;
    idle(6);
    chk(MICRO_WORD_UPPER, enc);
    FIFTH_TIME_PULSE = 1'b0;
    XFORM_NEXT_CMD = 1'b0;
    FETCH_AND_XFORM_N = 1'b1;
    idle(7);
    chk({15'h0, UPPER_ROM_DISABLE}, 16'h0000);
  endtask : xform

  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial
  begin
    idle(4);
    chk({8'h00, MICRO_ADDR_N}, 16'h00FF);
    chk({15'h0, PROTECT_STATE_N}, 16'h0001);
    chk({15'h0, BUS_OE_N}, 16'h0001);
    RST_B = 1'b1;
    idle(6);
    xform(16'hC207, 4'hF, 8'h67, 16'h0007, 1'b0, 16'hC698, 0);
    chk({15'h0, PROTECT_STATE_N}, 16'h0000);
    xform(16'h0812, 4'hF, 8'hCF, 16'hFFFF, 1'b1, 16'h0000, 0);
    xform(16'h0E34, 4'hF, 8'hB7, 16'h0134, 1'b1, 16'h0000, 0);
    xform(16'h0285, 4'hF, 8'hE7, 16'hFF85, 1'b1, 16'h0000, 0);
    xform(16'h004B, 4'hF, 8'hEF, 16'h000B, 1'b1, 16'h0000, 0);
    xform(16'h0456, 4'hF, 8'hDF, 16'h0056, 1'b0, 16'h0000, 1);
    xform(16'h5123, 4'hA, 8'h9F, 16'h0606, 1'b0, 16'hC698, 0);
    // rom word passes through when no transform is running
    FIFTH_TIME_PULSE = 1'b1;
    idle(6);
    chk(MICRO_WORD_UPPER, 16'hC560);
    FIFTH_TIME_PULSE = 1'b0;
    MICRO_WORD_LOAD_N = 1'b0;
    idle(6);
    chk({8'h00, MICRO_INSTR_REG}, 16'h0060);
    MICRO_WORD_LOAD_N = 1'b1;
    MICRO_WORD_CLEAR = 1'b1;
    idle(6);
    chk({8'h00, MICRO_INSTR_REG}, 16'h0000);
    MICRO_WORD_CLEAR = 1'b0;
    LOWER_WORD_BUS_GATE_N = 1'b0;
    idle(6);
    chk(BUS_LEVEL, 16'h9F60);
    UPPER_WORD_BUS_GATE_N = 1'b0;
    idle(6);
    chk(BUS_LEVEL, 16'h9F60);
    LOWER_WORD_BUS_GATE_N = 1'b1;
    idle(6);
    chk(BUS_LEVEL, 16'hC560);
    UPPER_WORD_BUS_GATE_N = 1'b1;
    idle(6);
    chk({15'h0, BUS_OE_N}, 16'h0001);
    chk({15'h0, ALU_A_FROM_OFFSET}, 16'h0001);
    DELTA_PATH_SELECT_BIT = 1'b1;
    idle(6);
    chk({15'h0, ALU_A_FROM_OFFSET}, 16'h0000);
    // holding register alone follows its own load gate
    MEM_DATA = 16'h1234;
    INSTR_REG_LOAD_N = 1'b0;
    idle(4);
    INSTR_REG_LOAD_N = 1'b1;
    idle(4);
    // top-location test, then a clock without store status must not latch
    MACRO_ADDR_REG = 16'h00FF;
    STORE_STATUS = 1'b1;
    idle(4);
    MEM_ADDR_REG_CLOCK_N = 1'b0;
    idle(6);
    chk({15'h0, INDEX_AT_TOP_LOCATION}, 16'h0001);
    chk({15'h0, UPPER_LOWER_SELECT_N}, 16'h0000);
    MEM_ADDR_REG_CLOCK_N = 1'b1;
    MACRO_ADDR_REG = 16'h0100;
    STORE_STATUS = 1'b0;
    idle(4);
    MEM_ADDR_REG_CLOCK_N = 1'b0;
    idle(6);
    chk({15'h0, INDEX_AT_TOP_LOCATION}, 16'h0001);
    MEM_ADDR_REG_CLOCK_N = 1'b1;
    STORE_STATUS = 1'b1;
    idle(4);
    MEM_ADDR_REG_CLOCK_N = 1'b0;
    idle(6);
    chk({15'h0, UPPER_LOWER_SELECT_N}, 16'h0001);
    MEM_ADDR_REG_CLOCK_N = 1'b1;
    // halt block is still low from the last transform
    LATE_MASTER_CLEAR_N = 1'b0;
    idle(6);
    chk({15'h0, PROTECT_STATE_N}, 16'h0001);
    chk({15'h0, HALT_INTR_BLOCK_N}, 16'h0001);
    LATE_MASTER_CLEAR_N = 1'b1;
    PROTECT_BIT = 1'b0;
    idle(4);
    xform(16'h0812, 4'hF, 8'hCF, 16'hFFFF, 1'b1, 16'h0000, 0);
    chk({15'h0, PROTECT_STATE_N}, 16'h0001);
    summarize();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #50000;
    fail_count++;
    summarize();
  end
endmodule : mxt_core_tb
